/* File: verilog/card_specific_data_register.sv */
// Functional notes
// - record bits 127..126 read binary 10 from the first clock edge after reset; the record reads all zero during reset.
// - bits 125..122 read 0011; bits 121..120 read zero.
// - access-time byte: exponent 2..0, mantissa 6..3, bit 7 zero.
// - access-time byte at 119..112 reads 0x26, meaning 1.5 ms.
// - clocked access byte at 111..104 counts hundreds of cycles, reads 0x01.
// - clocked access term never exceeds 25.6K clock cycles.
// - rate byte: exponent 2..0, mantissa 6..3, bit 7 zero.
// - rate byte at 103..96 reads 0x2A, meaning 20 Mbit/s.
// - non-programmable fields fixed, incl. class mask and read block code.
// - bits 79, 78, 77 and 76 all read zero.
// - size at 73..62, multiplier 49..47, currents 61..50, model values.
// - erase multiplier 41..37 reads 0x1F; erase size 46..42 per model.
// - bit 31 set, protect group size 0x3, default ecc zero.
// - speed factor 0x4, write block code 0x9, bit 21 zero, 20..16 zero.
// - low fields 15..1 programmable; copy flag resets to one.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module card_specific_data_register #(
    parameter logic [11:0] SIZE_CODE       = 12'h3D3,
    parameter logic [2:0]  SIZE_MULT       = 3'h6,
    parameter logic [4:0]  ERASE_UNIT_SIZE = 5'h07,
    parameter logic [11:0] SUPPLY_CURRENTS = 12'h000,
    parameter int          ASYNC_CYCLES    = record_pkg::ASYNC_CYCLES
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    input  wire logic [3:0]   pstrb,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    output logic      [127:0] card_specific_record
);
    logic [15:0]  prog_fields;
    logic         copy_locked;
    logic         perm_locked;
    logic [127:0] record_d;
    logic [127:0] record_q;
    logic [6:0]   crc_calc;
    logic         crc_match;
    logic [31:0]  latency_cycles;
    logic [31:0]  capacity_blocks;
    logic         access;
    logic         fire;
    logic         prog_wr;
    logic         erase_wr;
    logic [15:0]  prog_merged;
    logic [31:0]  rdata_d;
    logic         err_d;
    logic         pready_q;
    logic         pslverr_q;
    logic [31:0]  prdata_q;

    // crc7 over the record above the crc field, msb first
    function automatic logic [6:0] crc7(input logic [127:0] rec);
        logic [6:0] c;
        logic       fb;
        c  = 7'h00;
        fb = 1'b0;
        for (int i = record_pkg::STRUCT_HI; i >= record_pkg::CRC_SPAN_LO; i--) begin
            fb = rec[i] ^ c[6];
            c  = {c[5:0], 1'b0};
            if (fb) begin
                c = c ^ record_pkg::CRC_POLY;
            end
        end
        return c;
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        return (a == record_pkg::OFF_REC0) || (a == record_pkg::OFF_REC1)
            || (a == record_pkg::OFF_REC2) || (a == record_pkg::OFF_REC3)
            || (a == record_pkg::OFF_PROG) || (a == record_pkg::OFF_CTRL)
            || (a == record_pkg::OFF_STATUS) || (a == record_pkg::OFF_LATENCY)
            || (a == record_pkg::OFF_CAPACITY);
    endfunction

    function automatic logic addr_writable(input logic [7:0] a);
        return (a == record_pkg::OFF_PROG) || (a == record_pkg::OFF_CTRL);
    endfunction

    // record assembly
    always_comb begin
        record_d = '0;
        record_d[record_pkg::STRUCT_HI:record_pkg::STRUCT_LO]   = record_pkg::STRUCT_VAL;
        record_d[record_pkg::PROTO_HI:record_pkg::PROTO_LO]     = record_pkg::PROTO_VAL;
        // bit 7 of the constant is zero, exponent and mantissa as coded
        record_d[record_pkg::ASYNC_HI:record_pkg::ASYNC_LO]     = record_pkg::ASYNC_VAL;
        record_d[record_pkg::ASYNC_HI]                          = 1'b0;
        record_d[record_pkg::CLOCKED_HI:record_pkg::CLOCKED_LO] = record_pkg::CLOCKED_VAL;
        record_d[record_pkg::RATE_HI:record_pkg::RATE_LO]       = record_pkg::RATE_VAL;
        record_d[record_pkg::RATE_HI]                           = 1'b0;
        record_d[record_pkg::CLASS_HI:record_pkg::CLASS_LO]     = record_pkg::CLASS_VAL;
        record_d[record_pkg::RBL_HI:record_pkg::RBL_LO]         = record_pkg::RBL_VAL;
        record_d[record_pkg::PART_RD_BIT]                       = 1'b0;
        record_d[record_pkg::WR_CROSS_BIT]                      = 1'b0;
        record_d[record_pkg::RD_CROSS_BIT]                      = 1'b0;
        record_d[record_pkg::DRIVER_BIT]                        = 1'b0;
        record_d[record_pkg::SIZE_HI:record_pkg::SIZE_LO]       = SIZE_CODE;
        record_d[record_pkg::CURR_HI:record_pkg::CURR_LO]       = SUPPLY_CURRENTS;
        record_d[record_pkg::SMULT_HI:record_pkg::SMULT_LO]     = SIZE_MULT;
        record_d[record_pkg::EUSIZE_HI:record_pkg::EUSIZE_LO]   = ERASE_UNIT_SIZE;
        record_d[record_pkg::EUMULT_HI:record_pkg::EUMULT_LO]   = record_pkg::EUMULT_VAL;
        record_d[record_pkg::PGSIZE_HI:record_pkg::PGSIZE_LO]   = record_pkg::PGSIZE_VAL;
        record_d[record_pkg::PGEN_BIT]                          = 1'b1;
        record_d[record_pkg::DECC_HI:record_pkg::DECC_LO]       = record_pkg::DECC_VAL;
        record_d[record_pkg::WSF_HI:record_pkg::WSF_LO]         = record_pkg::WSF_VAL;
        record_d[record_pkg::WBL_HI:record_pkg::WBL_LO]         = record_pkg::WBL_VAL;
        record_d[record_pkg::PART_WR_BIT]                       = 1'b0;
        record_d[record_pkg::FMT_GRP_BIT:record_pkg::CRC_LO]    =
            prog_fields[record_pkg::FMT_GRP_BIT:record_pkg::CRC_LO];
        record_d[record_pkg::ONE_BIT]                           = 1'b1;
    end

    // registered copy so the card-side reader sees a stable word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            record_q <= '0;
        end else begin
            record_q <= record_d;
        end
    end

    assign card_specific_record = record_q;

    // derived read-only views
    // crc is only advisory: software programs the crc field itself
    assign crc_calc  = crc7(record_q);
    assign crc_match = (crc_calc == record_q[record_pkg::CRC_HI:record_pkg::CRC_LO]);

    // clocked term is one unit of 100 cycles, far under the 25.6K ceiling
    always_comb begin
        logic [31:0] clocked;
        clocked = 32'(record_pkg::CLOCKED_VAL) * 32'(record_pkg::CLOCKED_UNIT);
        if (clocked > 32'(record_pkg::CLOCKED_MAX)) begin
            clocked = 32'(record_pkg::CLOCKED_MAX);
        end
        latency_cycles = 32'(ASYNC_CYCLES) + clocked;
    end

    // (size+1) << (mult+2); at most 2^21, fits in a word
    assign capacity_blocks = (32'(SIZE_CODE) + 32'h0000_0001)
                             << (32'(SIZE_MULT) + 32'(record_pkg::SMULT_BIAS));

    // apb slave
    assign access   = psel && penable;
    assign fire     = access && pready_q && !pslverr_q;
    assign prog_wr  = fire && pwrite && (paddr == record_pkg::OFF_PROG);
    assign erase_wr = fire && pwrite && (paddr == record_pkg::OFF_CTRL)
                      && pwdata[record_pkg::CTRL_ERASE_BIT] && pstrb[0];

    // byte lanes outside the strobe keep the stored value
    always_comb begin
        prog_merged = prog_fields;
        if (pstrb[0]) begin
            prog_merged[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            prog_merged[15:8] = pwdata[15:8];
        end
    end

    prog_field_store prog_field_store_i (
        .pclk          (pclk),
        .presetn       (presetn),
        .wr_en         (prog_wr),
        .wr_data       (prog_merged),
        .erase         (erase_wr),
        .fields_q      (prog_fields),
        .copy_locked_q (copy_locked),
        .perm_locked_q (perm_locked)
    );

    always_comb begin
        rdata_d = 32'h0000_0000;
        err_d   = !addr_known(paddr) || (pwrite && !addr_writable(paddr));
        if (!pwrite) begin
            unique case (paddr)
                record_pkg::OFF_REC0:     rdata_d = record_q[31:0];
                record_pkg::OFF_REC1:     rdata_d = record_q[63:32];
                record_pkg::OFF_REC2:     rdata_d = record_q[95:64];
                record_pkg::OFF_REC3:     rdata_d = record_q[127:96];
                record_pkg::OFF_PROG:     rdata_d = {16'h0000, prog_fields};
                record_pkg::OFF_STATUS: begin
                    rdata_d[record_pkg::ST_COPY_BIT]  = copy_locked;
                    rdata_d[record_pkg::ST_PERM_BIT]  = perm_locked;
                    rdata_d[record_pkg::ST_MATCH_BIT] = crc_match;
                    rdata_d[record_pkg::ST_CRC_LO +: 7] = crc_calc;
                end
                record_pkg::OFF_LATENCY:  rdata_d = latency_cycles;
                record_pkg::OFF_CAPACITY: rdata_d = capacity_blocks;
                default:                  rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // one wait state: answer is computed in the first access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= access && !pready_q;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr_q <= 1'b0;
        end else if (access && !pready_q) begin
            pslverr_q <= err_d;
        end else begin
            pslverr_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (access && !pready_q) begin
            prdata_q <= err_d ? 32'h0000_0000 : rdata_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
endmodule
`default_nettype wire

/* File: verilog/record_pkg.sv */
`default_nettype none
package record_pkg;
    // apb layout
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          STRB_W          = 4;
    localparam logic [7:0]  OFF_REC0        = 8'h00;
    localparam logic [7:0]  OFF_REC1        = 8'h04;
    localparam logic [7:0]  OFF_REC2        = 8'h08;
    localparam logic [7:0]  OFF_REC3        = 8'h0C;
    localparam logic [7:0]  OFF_PROG        = 8'h10;
    localparam logic [7:0]  OFF_CTRL        = 8'h14;
    localparam logic [7:0]  OFF_STATUS      = 8'h18;
    localparam logic [7:0]  OFF_LATENCY     = 8'h1C;
    localparam logic [7:0]  OFF_CAPACITY    = 8'h20;
    localparam int          CTRL_ERASE_BIT  = 0;
    localparam int          ST_COPY_BIT     = 0;
    localparam int          ST_PERM_BIT     = 1;
    localparam int          ST_MATCH_BIT    = 2;
    localparam int          ST_CRC_LO       = 8;
    // record geometry
    localparam int          REC_W           = 128;
    localparam int          PROG_W          = 16;
    localparam int          STRUCT_HI       = 127;
    localparam int          STRUCT_LO       = 126;
    localparam int          PROTO_HI        = 125;
    localparam int          PROTO_LO        = 122;
    localparam int          ASYNC_HI        = 119;
    localparam int          ASYNC_LO        = 112;
    localparam int          CLOCKED_HI      = 111;
    localparam int          CLOCKED_LO      = 104;
    localparam int          RATE_HI         = 103;
    localparam int          RATE_LO         = 96;
    localparam int          CLASS_HI        = 95;
    localparam int          CLASS_LO        = 84;
    localparam int          RBL_HI          = 83;
    localparam int          RBL_LO          = 80;
    localparam int          PART_RD_BIT     = 79;
    localparam int          WR_CROSS_BIT    = 78;
    localparam int          RD_CROSS_BIT    = 77;
    localparam int          DRIVER_BIT      = 76;
    localparam int          SIZE_HI         = 73;
    localparam int          SIZE_LO         = 62;
    localparam int          CURR_HI         = 61;
    localparam int          CURR_LO         = 50;
    localparam int          SMULT_HI        = 49;
    localparam int          SMULT_LO        = 47;
    localparam int          EUSIZE_HI       = 46;
    localparam int          EUSIZE_LO       = 42;
    localparam int          EUMULT_HI       = 41;
    localparam int          EUMULT_LO       = 37;
    localparam int          PGSIZE_HI       = 36;
    localparam int          PGSIZE_LO       = 32;
    localparam int          PGEN_BIT        = 31;
    localparam int          DECC_HI         = 30;
    localparam int          DECC_LO         = 29;
    localparam int          WSF_HI          = 28;
    localparam int          WSF_LO          = 26;
    localparam int          WBL_HI          = 25;
    localparam int          WBL_LO          = 22;
    localparam int          PART_WR_BIT     = 21;
    localparam int          CRC_SPAN_LO     = 8;
    // programmable low field positions
    localparam int          FMT_GRP_BIT     = 15;
    localparam int          COPY_BIT        = 14;
    localparam int          PERM_BIT        = 13;
    localparam int          TMP_BIT         = 12;
    localparam int          FMT_HI          = 11;
    localparam int          FMT_LO          = 10;
    localparam int          ECC_HI          = 9;
    localparam int          ECC_LO          = 8;
    localparam int          CRC_HI          = 7;
    localparam int          CRC_LO          = 1;
    localparam int          ONE_BIT         = 0;
    // fixed values
    localparam logic [1:0]  STRUCT_VAL      = 2'h2;
    localparam logic [3:0]  PROTO_VAL       = 4'h3;
    localparam logic [7:0]  ASYNC_VAL       = 8'h26;
    localparam logic [7:0]  CLOCKED_VAL     = 8'h01;
    localparam logic [7:0]  RATE_VAL        = 8'h2A;
    localparam logic [11:0] CLASS_VAL       = 12'h0F5;
    localparam logic [3:0]  RBL_VAL         = 4'h9;
    localparam logic [4:0]  EUMULT_VAL      = 5'h1F;
    localparam logic [4:0]  PGSIZE_VAL      = 5'h03;
    localparam logic [1:0]  DECC_VAL        = 2'h0;
    localparam logic [2:0]  WSF_VAL         = 3'h4;
    localparam logic [3:0]  WBL_VAL         = 4'h9;
    localparam logic [15:0] PROG_RESET      = 16'h4001;
    localparam logic [6:0]  CRC_POLY        = 7'h09;
    localparam int          SMULT_BIAS      = 2;
    // timing
    localparam int          CLK_HZ          = 40000000;
    localparam int          ASYNC_ACCESS_US = 1500;
    localparam int          ASYNC_CYCLES    = (ASYNC_ACCESS_US * (CLK_HZ / 1000000) + 0);
    localparam int          CLOCKED_UNIT    = 100;
    localparam int          CLOCKED_MAX     = 256 * CLOCKED_UNIT;
endpackage
`default_nettype wire

/* File: verilog/prog_field_store.sv */
`timescale 1ns/1ps
`default_nettype none
module prog_field_store (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    input  wire logic        erase,
    output logic      [15:0] fields_q,
    output logic             copy_locked_q,
    output logic             perm_locked_q
);
    // copy flag is one-time: the first write locks it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            copy_locked_q <= 1'b0;
        end else if (wr_en) begin
            copy_locked_q <= 1'b1;
        end
    end

    assign perm_locked_q = fields_q[record_pkg::PERM_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fields_q <= record_pkg::PROG_RESET;
        end else begin
            // erase first so a write in the same cycle wins
            if (erase) begin
                fields_q[record_pkg::TMP_BIT] <= 1'b0;
                fields_q[record_pkg::ECC_HI:record_pkg::ECC_LO] <= 2'h0;
                fields_q[record_pkg::CRC_HI:record_pkg::CRC_LO] <= 7'h00;
            end
            if (wr_en) begin
                fields_q[record_pkg::FMT_GRP_BIT] <= wr_data[record_pkg::FMT_GRP_BIT];
                if (!copy_locked_q) begin
                    fields_q[record_pkg::COPY_BIT] <= wr_data[record_pkg::COPY_BIT];
                end
                // permanent protect never clears once set
                fields_q[record_pkg::PERM_BIT] <= fields_q[record_pkg::PERM_BIT]
                                                  | wr_data[record_pkg::PERM_BIT];
                fields_q[record_pkg::TMP_BIT] <= wr_data[record_pkg::TMP_BIT];
                fields_q[record_pkg::FMT_HI:record_pkg::FMT_LO] <=
                    wr_data[record_pkg::FMT_HI:record_pkg::FMT_LO];
                fields_q[record_pkg::ECC_HI:record_pkg::ECC_LO] <=
                    wr_data[record_pkg::ECC_HI:record_pkg::ECC_LO];
                fields_q[record_pkg::CRC_HI:record_pkg::CRC_LO] <=
                    wr_data[record_pkg::CRC_HI:record_pkg::CRC_LO];
            end
            fields_q[record_pkg::ONE_BIT] <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: dv/record_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module record_chk #(
    parameter logic [11:0] SIZE_CODE       = 12'h3D3,
    parameter logic [2:0]  SIZE_MULT       = 3'h6,
    parameter logic [4:0]  ERASE_UNIT_SIZE = 5'h07,
    parameter logic [11:0] SUPPLY_CURRENTS = 12'h000
) (
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pwrite,
    input wire logic [7:0]   paddr,
    input wire logic [31:0]  pwdata,
    input wire logic [3:0]   pstrb,
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr,
    input wire logic [127:0] card_specific_record
);
    logic         live_q;
    logic         seen1_q;
    logic         seen2_q;
    logic         prog_wr;
    logic [127:0] rec;
    assign rec = card_specific_record;
    assign prog_wr = psel && penable && pready && pwrite && !pslverr
                     && paddr == 8'h10 && pstrb[1:0] == 2'h3;
    // record is first loaded at the first edge after reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) live_q <= 1'b0;
        else live_q <= 1'b1;
    end
    // two-deep so the copy check starts after the record has followed the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen1_q <= 1'b0;
            seen2_q <= 1'b0;
        end else begin
            seen1_q <= seen1_q | prog_wr;
            seen2_q <= seen1_q;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_struct_version: assert property (live_q |-> rec[127:126] == 2'h2)
        else $error("structure version wrong");
    a_proto_version: assert property (live_q |-> rec[125:120] == 6'h0C)
        else $error("protocol version wrong");
    a_access_bytes: assert property (live_q |-> rec[119:96] == 24'h26012A)
        else $error("access or rate byte wrong");
    a_class_block: assert property (live_q |-> rec[95:76] == 20'h0F590)
        else $error("class mask or block fields wrong");
    a_size_fields: assert property (live_q |-> rec[75:47] ==
        {2'h0, SIZE_CODE, SUPPLY_CURRENTS, SIZE_MULT}) else $error("size fields wrong");
    a_erase_protect: assert property (live_q |-> rec[46:29] ==
        {ERASE_UNIT_SIZE, 5'h1F, 5'h03, 1'h1, 2'h0}) else $error("erase or protect wrong");
    a_write_fields: assert property (live_q |-> rec[28:16] == 13'h1240)
        else $error("write fields wrong");
    a_low_one: assert property (live_q |-> rec[0])
        else $error("record bit zero not one");
    a_prog_reflect: assert property (prog_wr |-> ##2 {rec[15], rec[12:1]} ==
        $past({pwdata[15], pwdata[12:1]}, 2)) else $error("programmed fields not shown");
    a_copy_frozen: assert property (seen2_q && $past(seen2_q) |-> $stable(rec[14]))
        else $error("copy flag changed after first write");
    a_ready_pulse: assert property (psel && $rose(penable) |=> pready ##1 !pready)
        else $error("ready not one cycle after access start");
    a_err_unmapped: assert property (psel && penable && pready && paddr > 8'h20 |->
        pslverr && prdata == 32'h0) else $error("unmapped access not refused");
endmodule
bind card_specific_data_register record_chk #(
    .SIZE_CODE(SIZE_CODE),
    .SIZE_MULT(SIZE_MULT),
    .ERASE_UNIT_SIZE(ERASE_UNIT_SIZE),
    .SUPPLY_CURRENTS(SUPPLY_CURRENTS)
) record_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .card_specific_record(card_specific_record));
`default_nettype wire

/* File: dv/host_apb_master.sv */
`timescale 1ns/1ps
`default_nettype none
module host_apb_master (
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end
    // a typical figure only: the card may take longer
    function automatic logic [31:0] total_read_latency(input int async_cycles,
                                                       input logic [7:0] clocked);
        return 32'(async_cycles) + 32'(clocked) * 32'h0000_0064;
    endfunction
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rdata, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= we;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // released address and data lines do not keep the old value
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

/* File: dv/card_specific_data_register_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module card_specific_data_register_tb;
    localparam logic [11:0] SIZE_CODE = 12'h3D3;
    localparam logic [2:0]  SIZE_MULT = 3'h6;
    localparam logic [4:0]  EU_SIZE   = 5'h07;
    localparam logic [11:0] CURRENTS  = 12'h000;
    localparam int          ASYNC_CYC = 10;
    logic         pclk;
    logic         presetn;
    logic         psel;
    logic         penable;
    logic         pwrite;
    logic [7:0]   paddr;
    logic [31:0]  pwdata;
    logic [3:0]   pstrb;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic [127:0] card_specific_record;
    logic [31:0]  rd;
    logic         err;
    logic [6:0]   crc;
    int           fails;
    int           checks_done;
    host_apb_master host_apb_master_i (.pclk(pclk), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb));
    card_specific_data_register #(.SIZE_CODE(SIZE_CODE), .SIZE_MULT(SIZE_MULT),
        .ERASE_UNIT_SIZE(EU_SIZE), .SUPPLY_CURRENTS(CURRENTS), .ASYNC_CYCLES(ASYNC_CYC)
    ) card_specific_data_register_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .card_specific_record(card_specific_record));
    function automatic logic [127:0] exp_rec(input logic [15:0] prog);
        return {2'h2, 4'h3, 2'h0, 8'h26, 8'h01, 8'h2A, 12'h0F5, 4'h9, 4'h0, 2'h0, SIZE_CODE,
                CURRENTS, SIZE_MULT, EU_SIZE, 5'h1F, 5'h03, 1'h1, 2'h0, 3'h4, 4'h9, 1'h0,
                5'h00, prog};
    endfunction
    // crc7, x^7+x^3+1, over record bits 127..8, msb first
    function automatic logic [6:0] crc_ref(input logic [127:0] r);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 127; i >= 8; i--) begin
            c = {c[5:0], 1'b0} ^ ((r[i] ^ c[6]) ? 7'h09 : 7'h00);
        end
        return c;
    endfunction
    task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err,
                          input string what);
        host_apb_master_i.xfer(1'b0, a, 32'h0, 4'h0, rd, err);
        check(what, rd, exp);
        check("read error flag", err, exp_err);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic exp_err);
        host_apb_master_i.xfer(1'b1, a, d, s, rd, err);
        check("write error flag", err, exp_err);
    endtask
    task automatic rec_chk(input logic [15:0] prog);
        logic [127:0] e;
        e = exp_rec(prog);
        for (int k = 0; k < 4; k++) rd_chk(8'(4 * k), e[32 * k +: 32], 1'b0, "record word");
        check("record port", card_specific_record, e);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        results();
    end
    initial begin
        presetn = 1'b0;
        fails = 0;
        checks_done = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rec_chk(16'h4001);
        wr(record_pkg::OFF_PROG, 32'h0000_0000, 4'h3, 1'b0);
        rec_chk(16'h0001);
        // copy flag already fixed by the first write
        wr(record_pkg::OFF_PROG, 32'h0000_FFFE, 4'h3, 1'b0);
        rec_chk(16'hBFFF);
        wr(record_pkg::OFF_CTRL, 32'h0000_0001, 4'h1, 1'b0);
        rd_chk(record_pkg::OFF_PROG, 32'h0000_AC01, 1'b0, "programmed fields");
        wr(record_pkg::OFF_REC0, 32'hFFFF_FFFF, 4'hF, 1'b1);
        wr(record_pkg::OFF_REC3, 32'h0000_0000, 4'hF, 1'b1);
        wr(record_pkg::OFF_STATUS, 32'hFFFF_FFFF, 4'hF, 1'b1);
        rec_chk(16'hAC01);
        rd_chk(8'h40, 32'h0, 1'b1, "unmapped read");
        rd_chk(record_pkg::OFF_LATENCY, host_apb_master_i.total_read_latency(ASYNC_CYC, 8'h01),
               1'b0, "read latency");
        rd_chk(record_pkg::OFF_CAPACITY, 32'h0003_D400, 1'b0, "capacity");
        rd_chk(record_pkg::OFF_CTRL, 32'h0, 1'b0, "control read");
        crc = crc_ref(exp_rec(16'hAC01));
        rd_chk(record_pkg::OFF_STATUS, {17'h0, crc, 8'h03}, 1'b0, "status flags");
        // same upper byte, so the programmed crc now matches the record
        wr(record_pkg::OFF_PROG, {16'h0000, 8'hAC, crc, 1'b1}, 4'h3, 1'b0);
        rd_chk(record_pkg::OFF_STATUS, {17'h0, crc, 8'h07}, 1'b0, "crc match");
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rec_chk(16'h4001);
        results();
    end
endmodule
`default_nettype wire
